// *** verilog/esgc_top.sv ***
// esgc_top: echo suppression, double-talk loss, noise guard, volume
//
// Contract
// - receive path attenuated unless far-end speech is detected
// - steady receive input gets attenuated once noise floor catches up
// - two-bit field at reg 2 bits 13:12 sets rx detector threshold
// - double-talk loss in tx and/or rx when enabled
// - noise guard squelches tx unless near-end speech is detected
// - volume is digital gain in 3 dB steps, an overload saturates and steps agc loss up 6 dB
// - select 0: suppress when no near speech; 1: far only
// - engaged receive suppression attenuates by 24 dB
// - volume code spans +30 to -12 dB, code 1111 mutes
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
module esgc_top #(
  parameter int unsigned DECAY_CYC = esgc_pkg::AGC_DECAY_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic [15:0] tx_in_sample,
  input  wire logic        tx_in_valid,
  input  wire logic [15:0] rx_in_sample,
  input  wire logic        rx_in_valid,
  output logic      [15:0] tx_out_sample,
  output logic             tx_out_valid,
  output logic      [15:0] rx_out_sample,
  output logic             rx_out_valid
);
  // ==========================================
  // control registers
  logic [3:0] rx_volume_level_q;
  logic [3:0] tx_volume_level_q;
  logic       noise_guard_select_q;
  logic [1:0] rx_suppress_detect_threshold_q;
  logic       dt_enable_q;
  logic [1:0] dt_tx_loss_q;
  logic [1:0] dt_rx_loss_q;
  logic [1:0] tx_supp_att_q;
  logic [1:0] tx_detect_threshold_q;

  // write decode
  logic wr_rx;
  logic wr_tx;
  logic wr_det;
  logic wr_sup;
  assign wr_rx  = reg_wr && reg_addr == esgc_pkg::REG_RXCTL;
  assign wr_tx  = reg_wr && reg_addr == esgc_pkg::REG_TXCTL;
  assign wr_det = reg_wr && reg_addr == esgc_pkg::REG_DETCTL;
  assign wr_sup = reg_wr && reg_addr == esgc_pkg::REG_SUPCTL;

  localparam int unsigned VL  = esgc_pkg::VOL_LSB;
  localparam int unsigned NG  = esgc_pkg::NGSEL_BIT;
  localparam int unsigned RT  = esgc_pkg::RX_SUPPRESS_DETECT_THRESHOLD_LSB;
  localparam int unsigned DE  = esgc_pkg::DTEN_BIT;
  localparam int unsigned DTT = esgc_pkg::DTTX_LSB;
  localparam int unsigned DTR = esgc_pkg::DTRX_LSB;
  localparam int unsigned TA  = esgc_pkg::TSATT_LSB;
  localparam int unsigned TT  = esgc_pkg::TXTHD_LSB;

  // register storage
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_volume_level_q              <= esgc_pkg::VOL_RESET;
      tx_volume_level_q              <= esgc_pkg::VOL_RESET;
      noise_guard_select_q           <= esgc_pkg::NGSEL_RESET;
      rx_suppress_detect_threshold_q <= esgc_pkg::THD_RESET;
      dt_enable_q                    <= 1'b0;
      dt_tx_loss_q                   <= 2'h0;
      dt_rx_loss_q                   <= 2'h0;
      tx_supp_att_q                  <= 2'h0;
      tx_detect_threshold_q          <= esgc_pkg::THD_RESET;
    end else begin
      if (wr_rx) begin
        rx_volume_level_q    <= reg_wdata[VL+3:VL];
        noise_guard_select_q <= reg_wdata[NG];
      end
      if (wr_tx)
        tx_volume_level_q <= reg_wdata[VL+3:VL];
      if (wr_det)
        rx_suppress_detect_threshold_q <= reg_wdata[RT+1:RT];
      if (wr_sup) begin
        dt_enable_q           <= reg_wdata[DE];
        dt_tx_loss_q          <= reg_wdata[DTT+1:DTT];
        dt_rx_loss_q          <= reg_wdata[DTR+1:DTR];
        tx_supp_att_q         <= reg_wdata[TA+1:TA];
        tx_detect_threshold_q <= reg_wdata[TT+1:TT];
      end
    end
  end

  // ==========================================
  // the two paths
  logic [15:0] tx_g_sample;
  logic        tx_g_valid;
  logic        near_speech;
  logic [2:0]  tx_agc;
  logic [15:0] rx_g_sample;
  logic        rx_g_valid;
  logic        far_speech;
  logic [2:0]  rx_agc;

  esgc_path #(.DECAY_CYC(DECAY_CYC)) u_tx (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .in_sample  (tx_in_sample),
    .in_valid   (tx_in_valid),
    .vol_code   (tx_volume_level_q),
    .thr_code   (tx_detect_threshold_q),
    .out_sample (tx_g_sample),
    .out_valid  (tx_g_valid),
    .speech     (near_speech),
    .agc_att    (tx_agc)
  );

  esgc_path #(.DECAY_CYC(DECAY_CYC)) u_rx (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .in_sample  (rx_in_sample),
    .in_valid   (rx_in_valid),
    .vol_code   (rx_volume_level_q),
    .thr_code   (rx_suppress_detect_threshold_q),
    .out_sample (rx_g_sample),
    .out_valid  (rx_g_valid),
    .speech     (far_speech),
    .agc_att    (rx_agc)
  );

  // ==========================================
  // suppression and double-talk decisions
  logic       dbl_talk;
  logic       tx_supp;
  logic       rx_supp;
  logic [2:0] tx_shift;
  logic [2:0] rx_shift;
  logic [2:0] tx_shift_q;
  logic [2:0] rx_shift_q;

  assign dbl_talk = dt_enable_q && near_speech && far_speech;
  assign tx_supp  = noise_guard_select_q ? (far_speech && !near_speech)
                                         : !near_speech;
  assign rx_supp  = !far_speech;
  assign tx_shift = dbl_talk ? 3'(dt_tx_loss_q)
                  : tx_supp  ? 3'(tx_supp_att_q) + 3'h1 : 3'h0;
  assign rx_shift = dbl_talk ? 3'(dt_rx_loss_q)
                  : rx_supp  ? esgc_pkg::RX_SUPP_SH : 3'h0;

  // output stage applies the loss to each sample
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_out_sample <= 16'h0000;
      rx_out_sample <= 16'h0000;
      tx_out_valid  <= 1'b0;
      rx_out_valid  <= 1'b0;
      tx_shift_q    <= 3'h0;
      rx_shift_q    <= esgc_pkg::RX_SUPP_SH;
    end else begin
      tx_out_valid <= tx_g_valid;
      rx_out_valid <= rx_g_valid;
      if (tx_g_valid) begin
        tx_out_sample <= 16'($signed(tx_g_sample) >>> tx_shift);
        tx_shift_q    <= tx_shift;
      end
      if (rx_g_valid) begin
        rx_out_sample <= 16'($signed(rx_g_sample) >>> rx_shift);
        rx_shift_q    <= rx_shift;
      end
    end
  end

  // ==========================================
  // read mux, data only in the cycle after the strobe
  logic [15:0] rd_mux;
  logic [15:0] status;
  assign status = (16'(near_speech) << esgc_pkg::ST_NEAR)
                | (16'(far_speech)  << esgc_pkg::ST_FAR)
                | (16'(dbl_talk)    << esgc_pkg::ST_DT)
                | (16'(tx_supp)     << esgc_pkg::ST_TXSUP)
                | (16'(rx_supp)     << esgc_pkg::ST_RXSUP)
                | (16'(tx_agc)      << esgc_pkg::ST_TXAGC)
                | (16'(rx_agc)      << esgc_pkg::ST_RXAGC);
  assign rd_mux =
    (reg_addr == esgc_pkg::REG_RXCTL) ?
      (16'(rx_volume_level_q) << VL) | (16'(noise_guard_select_q) << NG) :
    (reg_addr == esgc_pkg::REG_TXCTL) ? 16'(tx_volume_level_q) << VL :
    (reg_addr == esgc_pkg::REG_DETCTL) ?
      16'(rx_suppress_detect_threshold_q) << RT :
    (reg_addr == esgc_pkg::REG_SUPCTL) ?
      (16'(dt_enable_q) << DE) | (16'(dt_tx_loss_q) << DTT)
      | (16'(dt_rx_loss_q) << DTR) | (16'(tx_supp_att_q) << TA)
      | (16'(tx_detect_threshold_q) << TT) :
    (reg_addr == esgc_pkg::REG_STATUS) ? status : 16'h0000;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
  end

  // ==========================================
  // checks
  rx_supp_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rx_g_valid && !far_speech
    |=> rx_out_valid && rx_shift_q == esgc_pkg::RX_SUPP_SH)
    else $error("rx suppression not 24 dB");
  rx_open_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rx_g_valid && far_speech && !dbl_talk |=> rx_shift_q == 3'h0)
    else $error("rx suppression held during far speech");
  ng_squelch_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    tx_g_valid && !noise_guard_select_q && !near_speech
    |=> tx_shift_q == $past(tx_supp_att_q) + 3'h1)
    else $error("noise guard did not squelch tx");
  ng_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    tx_g_valid && noise_guard_select_q && !far_speech && !near_speech
    |=> tx_shift_q == 3'h0)
    else $error("tx suppressed without far speech");
  dt_loss_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    tx_g_valid && dt_enable_q && near_speech && far_speech
    |=> tx_shift_q == 3'($past(dt_tx_loss_q)))
    else $error("double-talk tx loss wrong");
  dt_only_both_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    tx_g_valid && dt_enable_q && near_speech && !far_speech
    |=> tx_shift_q == 3'h0)
    else $error("double-talk loss without far speech");
  thr_read_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    reg_rd && reg_addr == esgc_pkg::REG_DETCTL && !reg_wr
    |=> reg_rdata[13:12] == $past(rx_suppress_detect_threshold_q))
    else $error("rx threshold readback wrong");
  rd_pulse_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
endmodule : esgc_top

// *** include/esgc_pkg.sv ***
// esgc_pkg: constants for the echo suppression and gain control block
package esgc_pkg;
  // ==========================================
  // register map (index on the plain port)
  localparam int unsigned AW = 3;
  localparam int unsigned DW = 16;
  localparam logic [AW-1:0] REG_RXCTL  = 3'h0;
  localparam logic [AW-1:0] REG_TXCTL  = 3'h1;
  localparam logic [AW-1:0] REG_DETCTL = 3'h2;
  localparam logic [AW-1:0] REG_SUPCTL = 3'h3;
  localparam logic [AW-1:0] REG_STATUS = 3'h4;
  // ==========================================
  // field positions
  localparam int unsigned VOL_LSB   = 8;
  localparam int unsigned NGSEL_BIT = 4;
  localparam int unsigned RX_SUPPRESS_DETECT_THRESHOLD_LSB = 12;
  localparam int unsigned DTEN_BIT  = 0;
  localparam int unsigned DTTX_LSB  = 2;
  localparam int unsigned DTRX_LSB  = 4;
  localparam int unsigned TSATT_LSB = 6;
  localparam int unsigned TXTHD_LSB = 8;
  localparam int unsigned ST_NEAR   = 0;
  localparam int unsigned ST_FAR    = 1;
  localparam int unsigned ST_DT     = 2;
  localparam int unsigned ST_TXSUP  = 3;
  localparam int unsigned ST_RXSUP  = 4;
  localparam int unsigned ST_TXAGC  = 8;
  localparam int unsigned ST_RXAGC  = 12;
  // ==========================================
  // reset values
  localparam logic [3:0] VOL_RESET   = 4'ha;  // 0 dB
  localparam logic       NGSEL_RESET = 1'h1;  // guard off
  localparam logic [1:0] THD_RESET   = 2'h1;
  // ==========================================
  // gain law: code 0 is +30 dB, 3 dB per code
  localparam logic [3:0]  VOL_MUTE   = 4'hf;
  localparam logic [15:0] MANT_EVEN  = 16'h4000; // 1.0 in q14
  localparam logic [15:0] MANT_ODD   = 16'h2d41; // -3 dB in q14
  localparam logic [4:0]  GAIN_SHIFT = 5'h09;    // q14 minus 5 doublings
  localparam logic [2:0]  AGC_MAX    = 3'h7;
  localparam logic [2:0]  RX_SUPP_SH = 3'h4;     // 24 dB
  // ==========================================
  // detector
  localparam int unsigned ENV_SHIFT = 4;
  localparam logic [15:0] NF_RESET  = 16'h0010;
  localparam logic [15:0] NF_MAX    = 16'hffff;
  // ==========================================
  // timing
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned AGC_DECAY_MS = 30;
  localparam int unsigned AGC_DECAY_CYC =
    AGC_DECAY_MS * 1000 * CLK_MHZ;
endpackage : esgc_pkg

// *** verilog/esgc_path.sv ***
// esgc_path: speech detector plus agc backed volume for one path
`timescale 1ns/1ps
module esgc_path #(
  parameter int unsigned DECAY_CYC = esgc_pkg::AGC_DECAY_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [15:0] in_sample,
  input  wire logic        in_valid,
  input  wire logic [3:0]  vol_code,
  input  wire logic [1:0]  thr_code,
  output logic      [15:0] out_sample,
  output logic             out_valid,
  output logic             speech,
  output logic      [2:0]  agc_att
);
  // ==========================================
  // speech detector
  logic        [15:0] env_q;
  logic        [15:0] nf_q;
  logic        [15:0] mag;
  logic signed [16:0] diff;
  logic signed [16:0] step;
  logic        [19:0] thr_lvl;
  logic        [23:0] dec_q;

  localparam int unsigned ENV_SHIFT_C = esgc_pkg::ENV_SHIFT;

  // envelope follows magnitude, floor rises slowly
  assign mag     = in_sample[15] ? 16'(-in_sample) : in_sample;
  assign diff    = $signed({1'b0, mag}) - $signed({1'b0, env_q});
  assign step    = diff >>> ENV_SHIFT_C;
  assign thr_lvl = {4'h0, nf_q} << (3'(thr_code) + 3'h1);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      env_q  <= 16'h0000;
      nf_q   <= esgc_pkg::NF_RESET;
      speech <= 1'b0;
    end else if (in_valid) begin
      env_q  <= 16'($signed({1'b0, env_q}) + step);
      speech <= {4'h0, env_q} > thr_lvl;
      if (env_q < nf_q)
        nf_q <= env_q;
      else if (nf_q != esgc_pkg::NF_MAX)
        nf_q <= nf_q + 16'h0001;
    end
  end

  // ==========================================
  // volume gain with peak limiting
  logic signed [31:0] prod;
  logic signed [31:0] scaled;
  logic        [4:0]  sh;
  logic               over;
  logic               mute;
  logic        [15:0] sat;

  assign mute   = vol_code == esgc_pkg::VOL_MUTE;
  assign prod   = $signed(in_sample) * $signed(vol_code[0] ?
                  esgc_pkg::MANT_ODD : esgc_pkg::MANT_EVEN);
  assign sh     = esgc_pkg::GAIN_SHIFT + 5'(vol_code[3:1]) + 5'(agc_att);
  assign scaled = prod >>> sh;
  assign over   = (scaled > 32'sh00007fff) || (scaled < -32'sh00008000);
  assign sat    = over ? (prod[31] ? 16'h8000 : 16'h7fff)
                       : scaled[15:0];

  // output register and agc attack/decay
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      out_sample <= 16'h0000;
      out_valid  <= 1'b0;
      agc_att    <= 3'h0;
      dec_q      <= 24'h000000;
    end else begin
      out_valid <= in_valid;
      if (in_valid)
        out_sample <= mute ? 16'h0000 : sat;
      if (in_valid && over && !mute) begin
        dec_q <= 24'h000000;
        if (agc_att != esgc_pkg::AGC_MAX)
          agc_att <= agc_att + 3'h1;
      end else if (dec_q == 24'(DECAY_CYC - 1)) begin
        dec_q <= 24'h000000;
        if (agc_att != 3'h0)
          agc_att <= agc_att - 3'h1;
      end else begin
        dec_q <= dec_q + 24'h000001;
      end
    end
  end

  // ==========================================
  // checks
  mute_out_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    in_valid && mute |=> out_valid && out_sample == 16'h0000)
    else $error("muted code let signal through");
  agc_attack_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    in_valid && over && !mute && agc_att != esgc_pkg::AGC_MAX
    |=> agc_att == $past(agc_att) + 3'h1)
    else $error("agc did not attack on overload");
  floor_rise_a: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    in_valid && env_q >= nf_q && nf_q != esgc_pkg::NF_MAX
    |=> nf_q == $past(nf_q) + 16'h0001)
    else $error("noise floor did not rise");
endmodule : esgc_path

// *** sim/esgc_codec_model.sv ***
// esgc_codec_model: acoustic and network codecs feeding speech samples
`timescale 1ns/1ps
module esgc_codec_model (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        tx_req,
  input  wire logic        rx_req,
  input  wire logic [15:0] req_sample,
  output logic      [15:0] tx_in_sample,
  output logic             tx_in_valid,
  output logic      [15:0] rx_in_sample,
  output logic             rx_in_valid
);
  // ==========================================
  // one valid pulse per request, bus toggles to garbage between samples
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_in_valid  <= 1'b0;
      rx_in_valid  <= 1'b0;
      tx_in_sample <= 16'h0;
      rx_in_sample <= 16'h0;
    end else begin
      tx_in_valid  <= tx_req;
      rx_in_valid  <= rx_req;
      tx_in_sample <= tx_req ? req_sample : ~tx_in_sample;
      rx_in_sample <= rx_req ? req_sample : ~rx_in_sample;
    end
  end
endmodule : esgc_codec_model

// *** sim/esgc_tb_top.sv ***
// esgc_tb_top: self-checking bench for the suppression and volume block
`timescale 1ns/1ps
module esgc_tb_top;
  logic        clk_sys    = 1'b0;
  logic        reset_n    = 1'b0;
  logic [2:0]  reg_addr   = 3'h0;
  logic [15:0] reg_wdata  = 16'h0;
  logic        reg_wr     = 1'b0;
  logic        reg_rd     = 1'b0;
  logic        tx_req     = 1'b0;
  logic        rx_req     = 1'b0;
  logic [15:0] req_sample = 16'h0;
  logic [15:0] reg_rdata, tx_in_sample, rx_in_sample;
  logic [15:0] tx_out_sample, rx_out_sample, y, st;
  logic        tx_in_valid, rx_in_valid, tx_out_valid, rx_out_valid;
  int          errors          = 0;
  int          samples_checked = 0;
  logic [3:0]  gcode [7] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'hd, 4'he, 4'hf};
  logic [15:0] gexp  [7] = '{16'h0200, 16'h016a, 16'h0100, 16'h00b5,
                             16'h005a, 16'h0040, 16'h0000};

  // 250 MHz system clock
  always #2 clk_sys = ~clk_sys;

  esgc_codec_model i_esgc_codec_model (
    .clk_sys(clk_sys), .reset_n(reset_n), .tx_req(tx_req),
    .rx_req(rx_req), .req_sample(req_sample),
    .tx_in_sample(tx_in_sample), .tx_in_valid(tx_in_valid),
    .rx_in_sample(rx_in_sample), .rx_in_valid(rx_in_valid));

  esgc_top #(.DECAY_CYC(64)) i_esgc_top (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_in_sample(tx_in_sample),
    .tx_in_valid(tx_in_valid), .rx_in_sample(rx_in_sample),
    .rx_in_valid(rx_in_valid), .tx_out_sample(tx_out_sample),
    .tx_out_valid(tx_out_valid), .rx_out_sample(rx_out_sample),
    .rx_out_valid(rx_out_valid));

  // ==========================================
  // helpers
  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    if (errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic reset_dut();
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
  endtask : reset_dut

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : rd

  // one sample through tx (p=0) or rx (p=1), out taken in its valid cycle
  task automatic send(input logic p, input logic [15:0] x,
                      output logic [15:0] o);
    int n;
    @(posedge clk_sys);
    tx_req     <= !p;
    rx_req     <= p;
    req_sample <= x;
    @(posedge clk_sys);
    tx_req <= 1'b0;
    rx_req <= 1'b0;
    for (n = 0; n < 8; n++) begin
      @(negedge clk_sys);
      if ((p ? rx_out_valid : tx_out_valid) === 1'b1) break;
    end
    if (n == 8) begin
      errors++;
      $display("ERROR out_valid expected 1 seen 0");
    end
    o = p ? rx_out_sample : tx_out_sample;
  endtask : send

  // feed loud speech until a status flag reaches the wanted level
  task automatic feed(input logic do_tx, input logic do_rx,
                      input int bitn, input logic want);
    int n;
    n = 0;
    do begin
      if (do_tx) send(1'b0, 16'h4000, y);
      if (do_rx) send(1'b1, 16'h0400, y);
      rd(esgc_pkg::REG_STATUS, st);
      n++;
    end while (st[bitn] !== want && n < 600);
  endtask : feed

  // ==========================================
  // watchdog
  initial begin
    repeat (40000) @(posedge clk_sys);
    errors++;
    give_verdict();
  end

  // ==========================================
  // test sequence
  initial begin
    reset_dut();
    // reset values, read-only status, unmapped index
    rd(esgc_pkg::REG_RXCTL, y);  check("rxctl", y, 16'h0a10);
    rd(esgc_pkg::REG_TXCTL, y);  check("txctl", y, 16'h0a00);
    rd(esgc_pkg::REG_DETCTL, y); check("detctl", y, 16'h1000);
    rd(esgc_pkg::REG_STATUS, y); check("status", y, 16'h0010);
    wr(esgc_pkg::REG_STATUS, 16'hffff);
    rd(esgc_pkg::REG_STATUS, y); check("status_ro", y, 16'h0010);
    wr(3'h5, 16'hffff);
    rd(3'h5, y);                 check("unmapped", y, 16'h0000);
    wr(esgc_pkg::REG_DETCTL, 16'hffff);
    rd(esgc_pkg::REG_DETCTL, y); check("thr_ones", y, 16'h3000);
    wr(esgc_pkg::REG_DETCTL, 16'h1000);
    // receive path attenuated by 24 dB with no far speech
    send(1'b1, 16'h0100, y);     check("rx_supp", y, 16'h0010);
    // volume steps of 3 dB down to mute
    for (int i = 0; i < 7; i++) begin
      wr(esgc_pkg::REG_TXCTL, {4'h0, gcode[i], 8'h00});
      send(1'b0, 16'h0100, y);   check("tx_vol", y, gexp[i]);
    end
    wr(esgc_pkg::REG_RXCTL, 16'h0f10);
    send(1'b1, 16'h0100, y);     check("rx_mute", y, 16'h0000);
    // +30 dB overload saturates instead of wrapping, agc attacks then decays
    reset_dut();
    wr(esgc_pkg::REG_TXCTL, 16'h0000);
    send(1'b0, 16'h4000, y);     check("no_wrap", y, 16'h7fff);
    rd(esgc_pkg::REG_STATUS, st);
    check("agc_on", {13'h0, st[10:8]}, 16'h0001);
    repeat (600) @(posedge clk_sys);
    rd(esgc_pkg::REG_STATUS, st);
    check("agc_off", {13'h0, st[10:8]}, 16'h0000);
    send(1'b0, 16'h0010, y);     check("tx_30db", y, 16'h0200);
    // noise guard on: squelch unless near speech
    reset_dut();
    wr(esgc_pkg::REG_RXCTL, 16'h0a00);
    wr(esgc_pkg::REG_SUPCTL, 16'h01c0);
    send(1'b0, 16'h0100, y);     check("guard_sq", y, 16'h0010);
    feed(1'b1, 1'b0, esgc_pkg::ST_NEAR, 1'b1);
    send(1'b0, 16'h4000, y);     check("guard_pass", y, 16'h4000);
    // guard off: far only suppresses tx; double-talk losses
    reset_dut();
    wr(esgc_pkg::REG_SUPCTL, 16'h01d9);
    feed(1'b0, 1'b1, esgc_pkg::ST_FAR, 1'b1);
    send(1'b1, 16'h0400, y);     check("rx_open", y, 16'h0400);
    send(1'b0, 16'h0100, y);     check("far_only", y, 16'h0010);
    feed(1'b1, 1'b1, esgc_pkg::ST_DT, 1'b1);
    check("dt_on", {15'h0, st[esgc_pkg::ST_DT]}, 16'h0001);
    send(1'b0, 16'h4000, y);     check("dt_tx", y, 16'h1000);
    send(1'b1, 16'h0400, y);     check("dt_rx", y, 16'h0200);
    // steady tone loses far speech, gets suppressed again
    feed(1'b0, 1'b1, esgc_pkg::ST_FAR, 1'b0);
    check("dt_off", {14'h0, st[2:1]}, 16'h0000);
    send(1'b1, 16'h0400, y);     check("tone_supp", y, 16'h0040);
    send(1'b0, 16'h4000, y);     check("dt_gone", y, 16'h4000);
    give_verdict();
  end
endmodule : esgc_tb_top
